// >>> src/lom_top.sv
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module lom_top import lom_pkg::*; #(
    parameter int TICK_CYC = int'(TICK_CYC_DEF)
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port receive indications
    input wire logic rx_frame,
    input wire logic rx_frame_err,
    input wire logic rx_sym,
    input wire logic rx_sym_err,
    input wire logic oam_reset,
    // Values reported by the remote peer
    input wire logic rem_wr,
    input wire logic [1:0] rem_kind,
    input wire logic [2:0] rem_field,
    input wire logic [63:0] rem_data,
    input wire logic rem_seq_wr,
    input wire logic [15:0] rem_seq,
    // Link event pulses
    output logic [NK-1:0] link_event
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_h;
        logic w_h;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic en;
        logic clr;
        logic [NK-1:0][63:0] win;
        logic [NK-1:0][63:0] thr;
        logic [NK-1:0][5:0][63:0] rem;
        logic [15:0] rseq;
        logic [31:0] tick_cnt;
        logic [3:0] sec_cnt;
        logic sec_err;
        logic [15:0] now;
        logic [NK-1:0] ev_out;
    } lom_st_t;

    lom_st_t st_r, st_nxt;
    logic tick;
    logic sec_end;
    logic efs_err;
    logic sub_clr;
    logic [NK-1:0] adv_v;
    logic [NK-1:0] err_v;
    logic [NK-1:0][63:0] cur_v;
    logic [NK-1:0][63:0] tot_v;
    logic [NK-1:0][31:0] evts_v;
    logic [NK-1:0][15:0] ts_v;
    logic [NK-1:0] ev_v;
    logic [NK-1:0][5:0][63:0] loc;
    logic [11:0] wa;
    logic [11:0] ra;
    logic [1:0] wk;
    logic [3:0] wf;
    logic [31:0] cw;

    function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [63:0] wmask(input int w);
        return w >= 64 ? 64'hffffffffffffffff : (64'h1 << w) - 64'h1;
    endfunction

    function automatic logic [31:0] rd_fld(input logic [3:0] f, input logic [5:0][63:0] v);
        logic [63:0] w;
        w = v[f[3:1]];
        return f[0] ? w[63:32] : w[31:0];
    endfunction

    // 100 ms time base; errored seconds are judged over ten ticks
    assign tick = st_r.tick_cnt == 32'(TICK_CYC - 1);
    assign sec_end = tick && st_r.sec_cnt == SEC_TICKS - 4'h1;
    assign efs_err = sec_end && (st_r.sec_err || rx_frame_err);
    assign sub_clr = st_r.clr || oam_reset;
    // Windows advance on time, frames, symbols and time again
    assign adv_v = {tick, rx_sym, rx_frame, tick};
    assign err_v = {efs_err, rx_sym_err, rx_frame_err, rx_frame_err};

    // One monitor per event kind; widths of count and total differ per kind
    for (genvar g = 0; g < NK; g++) begin : g_win
        lom_win #(
            .CW(CUR_W[g]),
            .TW(TOT_W[g])
        ) u_win (
            .aclk(aclk),
            .aresetn(aresetn),
            .clr(sub_clr),
            .en(st_r.en),
            .adv(adv_v[g]),
            .err(err_v[g]),
            .win(st_r.win[g]),
            .thr(st_r.thr[g]),
            .now(st_r.now),
            .cur(cur_v[g]),
            .tot(tot_v[g]),
            .evts(evts_v[g]),
            .ts(ts_v[g]),
            .ev(ev_v[g])
        );
        assign loc[g] = {48'h0, ts_v[g], 32'h0, evts_v[g], tot_v[g], cur_v[g],
                         st_r.thr[g], st_r.win[g]};
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.clr = 1'b0;
        st_nxt.ev_out = ev_v;
        wa = 12'h0;
        ra = s_axi_araddr;
        wk = 2'h0;
        wf = 4'h0;
        cw = 32'h0;
        st_nxt.tick_cnt = tick ? 32'h0 : st_r.tick_cnt + 32'h1;
        if (tick) begin
            st_nxt.now = st_r.now + 16'h1;
            st_nxt.sec_cnt = sec_end ? 4'h0 : st_r.sec_cnt + 4'h1;
        end
        if (sec_end) begin
            st_nxt.sec_err = 1'b0;
        end else if (rx_frame_err) begin
            st_nxt.sec_err = 1'b1;
        end
        // Remote set is loaded as the peer's reports are parsed
        if (rem_wr && rem_field < RF_N) begin
            st_nxt.rem[rem_kind][rem_field] = rem_data;
        end
        if (rem_seq_wr) begin
            st_nxt.rseq = rem_seq;
        end
        // Write channel: address and data may arrive in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_h = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_h = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_nxt.aw_h && st_nxt.w_h) begin
            st_nxt.aw_h = 1'b0;
            st_nxt.w_h = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_ERR;
            wa = st_nxt.awaddr;
            wk = wa[7:6];
            wf = wa[5:2];
            if (wa == A_CTRL) begin
                cw = merge32({30'h0, st_r.clr, st_r.en}, st_nxt.wdata, st_nxt.wstrb);
                st_nxt.en = cw[CTRL_EN];
                st_nxt.clr = cw[CTRL_CLR];
                st_nxt.bresp = RESP_OK;
            end else if (wa[11:8] == RG_LOC && wa[1:0] == 2'h0 && wf <= F_THR_HI) begin
                st_nxt.bresp = RESP_OK;
                case (wf)
                    F_WIN_LO: begin
                        st_nxt.win[wk][31:0] = merge32(st_r.win[wk][31:0], st_nxt.wdata,
                                                       st_nxt.wstrb);
                    end
                    F_WIN_HI: begin
                        st_nxt.win[wk][63:32] = merge32(st_r.win[wk][63:32], st_nxt.wdata,
                                                        st_nxt.wstrb);
                    end
                    F_THR_LO: begin
                        st_nxt.thr[wk][31:0] = merge32(st_r.thr[wk][31:0], st_nxt.wdata,
                                                       st_nxt.wstrb);
                    end
                    default: begin
                        st_nxt.thr[wk][63:32] = merge32(st_r.thr[wk][63:32], st_nxt.wdata,
                                                        st_nxt.wstrb);
                    end
                endcase
                st_nxt.win[wk] = st_nxt.win[wk] & wmask(WIN_W[wk]);
                st_nxt.thr[wk] = st_nxt.thr[wk] & wmask(THR_W[wk]);
                // Out-of-range errored-frame windows are pulled to the nearest bound
                if (st_nxt.win[K_FRM] < FRM_WIN_MIN) begin
                    st_nxt.win[K_FRM] = FRM_WIN_MIN;
                end else if (st_nxt.win[K_FRM] > FRM_WIN_MAX) begin
                    st_nxt.win[K_FRM] = FRM_WIN_MAX;
                end
            end
        end
        st_nxt.awready = !st_nxt.aw_h && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_h && !st_nxt.bvalid;
        // Read channel: one read in flight, data registered
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OK;
            if (ra == A_CTRL) begin
                st_nxt.rdata = {30'h0, st_r.clr, st_r.en};
            end else if (ra == A_TIME) begin
                st_nxt.rdata = {16'h0, st_r.now};
            end else if (ra == A_RSEQ) begin
                st_nxt.rdata = {16'h0, st_r.rseq};
            end else if (ra[1:0] == 2'h0 && ra[11:8] == RG_LOC && ra[5:2] <= F_LAST) begin
                st_nxt.rdata = rd_fld(ra[5:2], loc[ra[7:6]]);
            end else if (ra[1:0] == 2'h0 && ra[11:8] == RG_REM && ra[5:2] <= F_LAST) begin
                st_nxt.rdata = rd_fld(ra[5:2], st_r.rem[ra[7:6]]);
            end else begin
                st_nxt.rdata = 32'h0;
                st_nxt.rresp = RESP_ERR;
            end
        end
        st_nxt.arready = !st_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.en <= CTRL_EN_RST;
            st_r.win <= WIN_RST;
            st_r.thr <= THR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign link_event = st_r.ev_out;

    property p_clamp;
        @(posedge aclk) disable iff (!aresetn)
            st_r.win[K_FRM] >= FRM_WIN_MIN && st_r.win[K_FRM] <= FRM_WIN_MAX;
    endproperty
    a_clamp: assert property (p_clamp) else $error("frame window out of range");

    property p_now;
        @(posedge aclk) disable iff (!aresetn) tick |=> st_r.now == $past(st_r.now) + 16'h1;
    endproperty
    a_now: assert property (p_now) else $error("time base not advanced on tick");

    property p_rem;
        @(posedge aclk) disable iff (!aresetn)
            rem_wr && rem_field < RF_N
            |=> st_r.rem[$past(rem_kind)][$past(rem_field)] == $past(rem_data);
    endproperty
    a_rem: assert property (p_rem) else $error("remote value not stored");

    property p_seq;
        @(posedge aclk) disable iff (!aresetn) rem_seq_wr |=> st_r.rseq == $past(rem_seq);
    endproperty
    a_seq: assert property (p_seq) else $error("remote sequence not stored");

    property p_evout;
        @(posedge aclk) disable iff (!aresetn) 1'b1 |=> link_event == $past(ev_v);
    endproperty
    a_evout: assert property (p_evout) else $error("link event not one cycle late");

    property p_base;
        @(posedge aclk) disable iff (!aresetn)
            st_r.tick_cnt < 32'(TICK_CYC) && st_r.sec_cnt < SEC_TICKS;
    endproperty
    a_base: assert property (p_base) else $error("time base counter overran");

    // The clear bit is a one-cycle pulse; a stuck bit would hold all counts at zero
    property p_clrp;
        @(posedge aclk) disable iff (!aresetn) st_r.clr |=> !st_r.clr;
    endproperty
    a_clrp: assert property (p_clrp) else $error("clear bit did not self-clear");
endmodule
`default_nettype wire

// >>> src/lom_pkg.sv
// What this block does
// - Keep the 16-bit sequence number of link events reported by the remote end.
// - Stamp each generated event with a 16-bit time in 100 ms units.
// - Errored-frame window: 16 bits of 100 ms, default 1 s, held within 1 s..1 min.
// - Errored-frame threshold 32 bits, default 1; event when window count reaches it.
// - Hold a 32-bit errored-frame count for the current window.
// - Keep a 64-bit total of errored frames since sublayer reset.
// - Keep a 32-bit count of errored-frame events since sublayer reset.
// - Frame-period window is 32 bits, counted in received frames.
// - Frame-period threshold 32 bits; event when window errors reach it.
// - Hold a 32-bit frame-error count for the current frame-period window.
// - Keep a 64-bit total of frame-period errors since sublayer reset.
// - Keep a 32-bit count of frame-period events since sublayer reset.
// - Symbol-period window is 64 bits, counted in received symbols.
// - Symbol-period threshold 64 bits; event when window symbol errors reach it.
// - Hold a 64-bit symbol-error count for the current window.
// - Keep a 64-bit total of symbol errors since sublayer reset.
// - Keep a 32-bit count of symbol-period events since sublayer reset.
// - Errored-seconds summary window is 16 bits unsigned, 100 ms units.
// - Errored-seconds threshold 16 bits; event when window seconds reach it.
// - Keep a local set and a remote-reported set of all these values.
// - Keep a 32-bit total of errored frame seconds since sublayer reset.
// - Keep a 32-bit count of errored-seconds summary events since sublayer reset.
package lom_pkg;
    localparam int NK = 4;
    localparam logic [1:0] K_FRM = 2'h0;
    localparam logic [1:0] K_FP = 2'h1;
    localparam logic [1:0] K_SYM = 2'h2;
    localparam logic [1:0] K_EFS = 2'h3;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_TIME = 12'h004;
    localparam logic [11:0] A_RSEQ = 12'h300;
    localparam logic [3:0] RG_LOC = 4'h1;
    localparam logic [3:0] RG_REM = 4'h2;
    localparam logic [3:0] F_WIN_LO = 4'h0;
    localparam logic [3:0] F_WIN_HI = 4'h1;
    localparam logic [3:0] F_THR_LO = 4'h2;
    localparam logic [3:0] F_THR_HI = 4'h3;
    localparam logic [3:0] F_LAST = 4'hb;
    localparam logic [2:0] RF_N = 3'h6;
    localparam int CTRL_EN = 0;
    localparam int CTRL_CLR = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int WIN_W [NK] = '{16, 32, 64, 16};
    localparam int THR_W [NK] = '{32, 32, 64, 16};
    localparam int CUR_W [NK] = '{32, 32, 64, 16};
    localparam int TOT_W [NK] = '{64, 64, 64, 32};
    localparam logic [NK-1:0][63:0] WIN_RST = {64'h258, 64'hf4240, 64'h3e8, 64'ha};
    localparam logic [NK-1:0][63:0] THR_RST = {64'h1, 64'h1, 64'h1, 64'h1};
    localparam logic [63:0] FRM_WIN_MIN = 64'ha;
    localparam logic [63:0] FRM_WIN_MAX = 64'h258;
    localparam longint TICK_MS = 100;
    localparam longint CLK_HZ = 25000000;
    localparam longint TICK_CYC_DEF = TICK_MS * CLK_HZ / 1000;
    localparam logic [3:0] SEC_TICKS = 4'ha;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// >>> src/lom_win.sv
`timescale 1ns/100ps
`default_nettype none
module lom_win import lom_pkg::*; #(
    parameter int CW = 32,
    parameter int TW = 64
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic clr,
    input wire logic en,
    input wire logic adv,
    input wire logic err,
    input wire logic [63:0] win,
    input wire logic [63:0] thr,
    input wire logic [15:0] now,
    // Results
    output logic [63:0] cur,
    output logic [63:0] tot,
    output logic [31:0] evts,
    output logic [15:0] ts,
    output logic ev
);
    localparam logic [63:0] CMAX = CW >= 64 ? 64'hffffffffffffffff : (64'h1 << CW) - 64'h1;
    localparam logic [63:0] TMAX = TW >= 64 ? 64'hffffffffffffffff : (64'h1 << TW) - 64'h1;

    typedef struct packed {
        logic [63:0] pos;
        logic [63:0] cur;
        logic [63:0] tot;
        logic [31:0] evts;
        logic [15:0] ts;
        logic ev;
    } lom_win_st_t;

    lom_win_st_t st_r, st_nxt;
    logic close;
    logic [63:0] cnt;

    function automatic logic [63:0] inc_sat(input logic [63:0] v, input logic [63:0] m);
        return v == m ? v : v + 64'h1;
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.ev = 1'b0;
        close = 1'b0;
        cnt = st_r.cur;
        if (clr) begin
            st_nxt = '0;
        end else if (en) begin
            if (err) begin
                cnt = inc_sat(st_r.cur, CMAX);
                st_nxt.tot = inc_sat(st_r.tot, TMAX);
            end
            st_nxt.cur = cnt;
            if (adv) begin
                st_nxt.pos = st_r.pos + 64'h1;
                // A zero window closes on every unit rather than never
                if (st_nxt.pos >= win) begin
                    close = 1'b1;
                    st_nxt.pos = 64'h0;
                    st_nxt.cur = 64'h0;
                    if (cnt >= thr) begin
                        st_nxt.ev = 1'b1;
                        st_nxt.evts = 32'(inc_sat(64'(st_r.evts), 64'hffffffff));
                        st_nxt.ts = now;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cur = st_r.cur;
    assign tot = st_r.tot;
    assign evts = st_r.evts;
    assign ts = st_r.ts;
    assign ev = st_r.ev;

    property p_restart;
        @(posedge aclk) disable iff (!aresetn) en && !clr && close |=> cur == 64'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("window count not restarted");

    property p_event;
        @(posedge aclk) disable iff (!aresetn)
            en && !clr && close && cnt >= thr |=> ev && ts == $past(now);
    endproperty
    a_event: assert property (p_event) else $error("event missed at threshold");

    property p_noev;
        @(posedge aclk) disable iff (!aresetn) !(en && !clr && close) |=> !ev;
    endproperty
    a_noev: assert property (p_noev) else $error("event outside window close");

    property p_tot;
        @(posedge aclk) disable iff (!aresetn)
            en && !clr && err && tot != TMAX |=> tot == $past(tot) + 64'h1;
    endproperty
    a_tot: assert property (p_tot) else $error("running total not advanced");

    property p_clr;
        @(posedge aclk) disable iff (!aresetn)
            clr |=> tot == 64'h0 && evts == 32'h0 && cur == 64'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("sublayer reset did not clear");

    property p_cur;
        @(posedge aclk) disable iff (!aresetn) cur <= CMAX;
    endproperty
    a_cur: assert property (p_cur) else $error("window count beyond its width");
endmodule
`default_nettype wire

// >>> bench/lom_peer.sv
`timescale 1ns/100ps
`default_nettype none
module lom_peer (
    // Clock
    input wire logic aclk,
    // Remote report load
    output logic rem_wr,
    output logic [1:0] rem_kind,
    output logic [2:0] rem_field,
    output logic [63:0] rem_data,
    output logic rem_seq_wr,
    output logic [15:0] rem_seq
);
    initial begin
        rem_wr = 1'b0;
        rem_kind = 2'h0;
        rem_field = 3'h0;
        rem_data = 64'h0;
        rem_seq_wr = 1'b0;
        rem_seq = 16'h0;
    end
    // A slow peer waits gap+1 cycles; released lines show the inverse of the last value
    task automatic report(input logic [1:0] k, input logic [2:0] f, input logic [63:0] d,
                          input int gap);
        repeat (gap + 1) @(posedge aclk);
        rem_wr <= 1'b1;
        rem_kind <= k;
        rem_field <= f;
        rem_data <= d;
        @(posedge aclk);
        rem_wr <= 1'b0;
        rem_kind <= ~k;
        rem_field <= ~f;
        rem_data <= ~d;
    endtask
    task automatic report_seq(input logic [15:0] s, input int gap);
        repeat (gap + 1) @(posedge aclk);
        rem_seq_wr <= 1'b1;
        rem_seq <= s;
        @(posedge aclk);
        rem_seq_wr <= 1'b0;
        rem_seq <= ~s;
    endtask
endmodule
`default_nettype wire

// >>> bench/lom_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lom_top_tb import lom_pkg::*; ;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic rx_frame = 1'b0, rx_frame_err = 1'b0, rx_sym = 1'b0, rx_sym_err = 1'b0;
    logic oam_reset = 1'b0;
    logic rem_wr, rem_seq_wr;
    logic [1:0] rem_kind;
    logic [2:0] rem_field;
    logic [63:0] rem_data;
    logic [15:0] rem_seq;
    logic [NK-1:0] link_event;
    int fails = 0;
    int tests_run = 0;
    // Short tick keeps the 100 ms time base affordable in simulation
    lom_top #(.TICK_CYC(20)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_frame(rx_frame),
        .rx_frame_err(rx_frame_err), .rx_sym(rx_sym), .rx_sym_err(rx_sym_err),
        .oam_reset(oam_reset), .rem_wr(rem_wr), .rem_kind(rem_kind),
        .rem_field(rem_field), .rem_data(rem_data), .rem_seq_wr(rem_seq_wr),
        .rem_seq(rem_seq), .link_event(link_event));
    lom_peer peer (.aclk(aclk), .rem_wr(rem_wr), .rem_kind(rem_kind), .rem_field(rem_field),
        .rem_data(rem_data), .rem_seq_wr(rem_seq_wr), .rem_seq(rem_seq));
    initial begin
        forever #20 aclk = ~aclk;
    end
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic hang();
        $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        fails++;
        print_verdict();
    endtask
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 100) hang();
    endtask
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 100) hang();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check(r, RESP_OK);
    endtask
    task automatic rd(input logic [11:0] a, input logic [63:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check({r, d}, {RESP_OK, exp[31:0]});
    endtask
    // Back-to-back unit pulses; the first nerr of them are errored
    task automatic pulse_units(input bit sym, input int n, input int nerr);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            rx_frame <= !sym;
            rx_frame_err <= !sym && i < nerr;
            rx_sym <= sym;
            rx_sym_err <= sym && i < nerr;
        end
        @(posedge aclk);
        {rx_frame, rx_frame_err, rx_sym, rx_sym_err} <= 4'h0;
    endtask
    task automatic wait_ev(input int i, input int lim, output bit hit);
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++) begin
            @(posedge aclk);
            hit = (link_event[i] === 1'b1);
        end
    endtask
    task automatic t_defaults();
        rd(A_CTRL, 64'h1);
        rd(12'h100, 64'ha);
        rd(12'h108, 64'h1);
        rd(12'h140, 64'h3e8);
        rd(12'h180, 64'hf4240);
        rd(12'h184, 64'h0);
        rd(12'h1c0, 64'h258);
        rd(12'h118, 64'h0);
        rd(12'h1d8, 64'h0);
    endtask
    task automatic t_config();
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h100, 32'h5);
        rd(12'h100, 64'ha);
        wr(12'h100, 32'h3e8);
        rd(12'h100, 64'h258);
        wr(12'h100, 32'ha);
        wr(12'h10c, 32'hffffffff);
        rd(12'h10c, 64'h0);
        wr(12'h1c8, 32'h0001ffff);
        rd(12'h1c8, 64'hffff);
        wr(12'h1c8, 32'h1);
        wr(12'h1c0, 32'h14);
        axi_read(12'h010, d, r);
        check({r, d}, {RESP_ERR, 32'h0});
        axi_write(12'h218, 32'h1, r);
        check(r, RESP_ERR);
    endtask
    task automatic t_frame_period();
        bit hit;
        wr(12'h140, 32'h4);
        wr(12'h148, 32'h2);
        pulse_units(1'b0, 4, 2);
        wait_ev(1, 8, hit);
        check(hit, 1'b1);
        rd(12'h160, 64'h1);
        rd(12'h158, 64'h2);
        rd(12'h150, 64'h0);
        pulse_units(1'b0, 2, 1);
        rd(12'h150, 64'h1);
        pulse_units(1'b0, 2, 0);
        wait_ev(1, 8, hit);
        check(hit, 1'b0);
        rd(12'h150, 64'h0);
        rd(12'h160, 64'h1);
        rd(12'h118, 64'h3);
    endtask
    task automatic t_symbol();
        bit hit;
        wr(12'h180, 32'h3);
        wr(12'h184, 32'h0);
        wr(12'h188, 32'h3);
        pulse_units(1'b1, 3, 3);
        wait_ev(2, 8, hit);
        check(hit, 1'b1);
        rd(12'h1a0, 64'h1);
        rd(12'h190, 64'h0);
        pulse_units(1'b1, 3, 2);
        wait_ev(2, 8, hit);
        check(hit, 1'b0);
        rd(12'h198, 64'h5);
        pulse_units(1'b1, 1, 1);
        rd(12'h190, 64'h1);
    endtask
    task automatic t_timed();
        bit hit;
        logic [31:0] ts, tm;
        logic [1:0] r;
        pulse_units(1'b0, 1, 1);
        wait_ev(0, 250, hit);
        check(hit, 1'b1);
        axi_read(12'h128, ts, r);
        axi_read(A_TIME, tm, r);
        check(ts != 0 && ts <= tm, 1'b1);
        axi_read(12'h120, ts, r);
        check(ts != 0, 1'b1);
        wait_ev(3, 1000, hit);
        check(hit, 1'b1);
        axi_read(12'h1e0, ts, r);
        check(ts != 0, 1'b1);
        axi_read(12'h1d8, ts, r);
        check(ts != 0, 1'b1);
    endtask
    task automatic t_remote();
        peer.report(K_FP, 3'h3, 64'h0123456789abcdef, 0);
        peer.report(K_SYM, 3'h5, 64'h1234, 3);
        peer.report_seq(16'h5a5a, 2);
        rd(12'h258, 64'h89abcdef);
        rd(12'h25c, 64'h01234567);
        rd(12'h2a8, 64'h1234);
        rd(A_RSEQ, 64'h5a5a);
    endtask
    task automatic t_reset();
        wr(A_CTRL, 32'h3);
        rd(A_CTRL, 64'h1);
        rd(12'h198, 64'h0);
        wr(A_CTRL, 32'h0);
        pulse_units(1'b1, 1, 1);
        rd(12'h198, 64'h0);
        wr(A_CTRL, 32'h1);
        pulse_units(1'b1, 1, 1);
        rd(12'h198, 64'h1);
        @(posedge aclk);
        oam_reset <= 1'b1;
        @(posedge aclk);
        oam_reset <= 1'b0;
        rd(12'h118, 64'h0);
        rd(12'h158, 64'h0);
        rd(12'h198, 64'h0);
        rd(12'h1a0, 64'h0);
        rd(12'h128, 64'h0);
        rd(12'h1e0, 64'h0);
        rd(12'h140, 64'h4);
        rd(12'h258, 64'h89abcdef);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_defaults();
        t_config();
        t_frame_period();
        t_symbol();
        t_timed();
        t_remote();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
